// [matc_ctrl.sv]
// Chosen here: the strobed register port.
`timescale 1ns/1ps
// Behaviour
// [R01] unicast_accept set: accept every frame with a station destination address.
// [R02] multicast_accept set: accept every frame with a group destination address.
// [R03] all_ones_accept set: accept every broadcast-addressed frame.
// [R04] filter_invert flips CAM sense: matched rejected, unmatched accepted.
// [R05] destination compared against CAM only while lookup_compare_on is set.
// [R06] send allowed only with send_allow; clearing it aborts the frame at once.
// [R07] send_stop_after_frame: finish the current frame, then start no more.
// [R08] short frames padded to 64 bytes unless pad_suppress is set.
// [R09] fcs_suppress set: no frame check sequence appended.
// [R10] quick_backoff set: shortened test back-off intervals used.
// [R11] deferral_counter_off set: the defer counter is disabled.
// [R12] writing control_frame_send one requests a pause or control frame.
// [R13] control_frame_send self-clears after the frame; writing zero does nothing.
// [R14] heartbeat_test_mode set: SQE test mode for 10 Mb/s MII.
// [R15] irq_fifo_starve: interrupt on FIFO running empty mid-frame.
// [R16] irq_long_deferral: interrupt after max deferral, 0.32768 or 3.2768 ms.
// [R17] irq_carrier_missing: interrupt if no carrier during a whole frame.
// [R18] irq_too_many_collisions: interrupt on 16 collisions in one frame.
// [R19] irq_collision_late: interrupt on collision after 64 byte times.
// [R20] irq_fifo_parity: interrupt on transmit FIFO parity error.
// [R21] irq_frame_done: interrupt for every frame sent or discarded.
// [R22] software wanting per-frame interrupts sets completion and all error enables.
// [R23] even first byte is station; odd non-broadcast is group address.
// [R24] each event sets its status flag; interrupt only when enabled.
// [R25] parity error sets its flag and, when enabled, clears send_allow.
// [R26] compare disabled means no frame counts as CAM-recognised.
// [R27] reserved control bits read zero and writes to them are ignored.
module matc_ctrl import matc_pkg::*; #(
  parameter int DEFER_100M_CYCLES = MAX_DEFER_100M_CYC,
  parameter int DEFER_10M_CYCLES = MAX_DEFER_10M_CYC
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [15:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // receive address filter
  input wire logic rx_dest_valid_i,
  input wire logic [47:0] rx_dest_addr_i,
  input wire logic cam_hit_i,
  output logic rx_decision_valid_o,
  output logic rx_accept_o,
  output logic cam_compare_o,
  // transmit engine handshake
  input wire logic tx_pending_i,
  input wire logic tx_busy_i,
  input wire logic tx_byte_i,
  input wire logic tx_fifo_empty_i,
  input wire logic tx_fifo_parity_i,
  input wire logic tx_frame_done_i,
  input wire logic tx_ctl_frame_done_i,
  input wire logic speed_10m_i,
  // line pins (asynchronous)
  input wire logic carrier_present_i,
  input wire logic collision_i,
  // transmit engine controls
  output logic tx_start_ok_o,
  output logic tx_abort_o,
  output logic pad_suppress_o,
  output logic fcs_suppress_o,
  output logic quick_backoff_o,
  output logic heartbeat_test_mode_o,
  output logic control_frame_req_o,
  output logic excess_abort_o,
  output logic tx_irq_o
);

  // software-visible registers
  logic [FC_WIDTH-1:0] filter_ctrl;
  logic [TC_WIDTH-1:0] tx_ctrl;
  logic [TS_WIDTH-1:0] tx_status;

  // line pin synchronisers and collision edge
  logic crs_meta;
  logic crs_sync;
  logic col_meta;
  logic col_sync;
  logic col_prev;
  logic col_pulse;

  // per-frame tracking, cleared at every frame end
  logic [4:0] coll_cnt;
  logic [6:0] byte_cnt;
  logic carrier_seen;

  // deferral timer
  logic [18:0] defer_cnt;
  logic [18:0] defer_limit;
  logic defer_hit;
  logic defer_fired;

  // event strobes of the current cycle
  logic ev_starve;
  logic ev_excess;
  logic ev_late;
  logic ev_nocarr;
  logic ev_parity;
  logic any_irq_event;

  // status update masks
  logic [TS_WIDTH-1:0] set_mask;
  logic [TS_WIDTH-1:0] clr_mask;
  logic [TS_WIDTH-1:0] next_tx_status;

  // register write decode
  logic wr_filter;
  logic wr_tx_ctrl;
  logic wr_tx_status;

  // destination class of the frame under test
  logic is_broadcast;
  logic is_group;
  logic is_station;
  logic cam_recognised;

  assign wr_filter = reg_wr_i && (reg_addr_i == ADDR_FILTER_CTRL);
  assign wr_tx_ctrl = reg_wr_i && (reg_addr_i == ADDR_TX_CTRL);
  assign wr_tx_status = reg_wr_i && (reg_addr_i == ADDR_TX_STATUS);

  // two-flop synchronisers for the line pins; only the second flop is used
  // col_prev trails col_sync so a jam held many cycles is counted once
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      crs_meta <= 1'b0;
      crs_sync <= 1'b0;
      col_meta <= 1'b0;
      col_sync <= 1'b0;
      col_prev <= 1'b0;
    end else begin
      crs_meta <= carrier_present_i;
      crs_sync <= crs_meta;
      col_meta <= collision_i;
      col_sync <= col_meta;
      col_prev <= col_sync;
    end
  end

  // one count per collision burst, not per cycle it stands
  assign col_pulse = col_sync && !col_prev;

  // address filter control; only the five defined bits are stored
  // reserved bits have no flop, so they cannot alter behaviour
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      filter_ctrl <= FILTER_CTRL_RST;
    end else if (wr_filter) begin
      filter_ctrl <= reg_wdata_i[FC_WIDTH-1:0]; // [R27]
    end
  end

  // destination class: group bit is the lsb of the first byte on the wire
  assign is_broadcast = &rx_dest_addr_i; // [R23]
  assign is_group = rx_dest_addr_i[40] && !is_broadcast; // [R23]
  assign is_station = !rx_dest_addr_i[40]; // [R23]
  // with compare off nothing is recognised, so the CAM term reduces to filter_invert alone
  assign cam_recognised = filter_ctrl[FC_LOOKUP_COMPARE_ON] && cam_hit_i; // [R05] [R26]

  // registered accept decision, one cycle after the destination strobe
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rx_decision_valid_o <= 1'b0;
      rx_accept_o <= 1'b0;
    end else begin
      rx_decision_valid_o <= rx_dest_valid_i;
      if (rx_dest_valid_i) begin
        rx_accept_o <= (cam_recognised ^ filter_ctrl[FC_FILTER_INVERT]) // [R04]
          || (is_station && filter_ctrl[FC_UNICAST_ACCEPT]) // [R01]
          || (is_group && filter_ctrl[FC_MULTICAST_ACCEPT]) // [R02]
          || (is_broadcast && filter_ctrl[FC_ALL_ONES_ACCEPT]); // [R03]
      end
    end
  end

  // tell the CAM whether to look up at all
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cam_compare_o <= 1'b0;
    end else begin
      cam_compare_o <= filter_ctrl[FC_LOOKUP_COMPARE_ON]; // [R05]
    end
  end

  // transmit control; send request bit is set-only from software
  // limitation: software cannot withdraw a control frame request once made
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tx_ctrl <= TX_CTRL_RST;
    end else begin
      if (wr_tx_ctrl) begin
        tx_ctrl[TC_CONTROL_FRAME_SEND-1:0] <= reg_wdata_i[TC_CONTROL_FRAME_SEND-1:0];
        tx_ctrl[TC_WIDTH-1:TC_CONTROL_FRAME_SEND+1] <=
          reg_wdata_i[TC_WIDTH-1:TC_CONTROL_FRAME_SEND+1]; // [R27]
      end
      // a new request in the same cycle as completion is kept
      if (wr_tx_ctrl && reg_wdata_i[TC_CONTROL_FRAME_SEND]) begin
        tx_ctrl[TC_CONTROL_FRAME_SEND] <= 1'b1; // [R12] [R13]
      end else if (tx_ctl_frame_done_i) begin
        tx_ctrl[TC_CONTROL_FRAME_SEND] <= 1'b0; // [R13]
      end
      // parity shutdown beats a simultaneous software enable for safety
      if (ev_parity && tx_ctrl[TC_IRQ_FIFO_PARITY]) begin
        tx_ctrl[TC_SEND_ALLOW] <= 1'b0; // [R25]
      end
    end
  end

  // start permission and immediate abort for the transmit engine
  // abort stands for as long as the engine stays busy with send_allow low
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tx_start_ok_o <= 1'b0;
      tx_abort_o <= 1'b0;
    end else begin
      // halt only blocks new starts, so the frame in flight completes
      tx_start_ok_o <= tx_ctrl[TC_SEND_ALLOW] // [R06]
        && !tx_ctrl[TC_SEND_STOP_AFTER_FRAME]; // [R07]
      tx_abort_o <= tx_busy_i && !tx_ctrl[TC_SEND_ALLOW]; // [R06]
    end
  end

  // static mode bits and the control frame request passed to the transmit engine
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pad_suppress_o <= 1'b0;
      fcs_suppress_o <= 1'b0;
      quick_backoff_o <= 1'b0;
      heartbeat_test_mode_o <= 1'b0;
      control_frame_req_o <= 1'b0;
    end else begin
      pad_suppress_o <= tx_ctrl[TC_PAD_SUPPRESS]; // [R08]
      fcs_suppress_o <= tx_ctrl[TC_FCS_SUPPRESS]; // [R09]
      quick_backoff_o <= tx_ctrl[TC_QUICK_BACKOFF]; // [R10]
      heartbeat_test_mode_o <= tx_ctrl[TC_HEARTBEAT_TEST_MODE]; // [R14]
      control_frame_req_o <= tx_ctrl[TC_CONTROL_FRAME_SEND]; // [R12]
    end
  end

  // per-frame tracking: collisions, bytes sent and carrier seen
  // frame end has priority so the next frame never inherits old counts
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      coll_cnt <= 5'h00;
      byte_cnt <= 7'h00;
      carrier_seen <= 1'b0;
    end else if (tx_frame_done_i) begin
      coll_cnt <= 5'h00;
      byte_cnt <= 7'h00;
      carrier_seen <= 1'b0;
    end else begin
      if (col_pulse && tx_busy_i && coll_cnt != MAX_COLLISIONS) begin
        coll_cnt <= coll_cnt + 5'h01;
      end
      // saturate: only "past the slot" matters
      if (tx_busy_i && tx_byte_i && byte_cnt != SLOT_BYTES) begin
        byte_cnt <= byte_cnt + 7'h01;
      end
      if (tx_busy_i && crs_sync) begin
        carrier_seen <= 1'b1;
      end
    end
  end

  // abort request once the sixteenth collision is counted
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      excess_abort_o <= 1'b0;
    end else begin
      excess_abort_o <= ev_excess;
    end
  end

  // defer counter runs while a frame waits behind carrier
  // limits are parameters so a bench can run with very short spans
  assign defer_limit = speed_10m_i ? DEFER_10M_CYCLES[18:0] : DEFER_100M_CYCLES[18:0];
  assign defer_hit = (defer_cnt == defer_limit - 19'h00001) && !defer_fired;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      defer_cnt <= 19'h00000;
      defer_fired <= 1'b0;
    end else if (tx_ctrl[TC_DEFERRAL_COUNTER_OFF] || !crs_sync || !tx_pending_i) begin
      defer_cnt <= 19'h00000; // [R11]
      defer_fired <= 1'b0;
    end else if (defer_hit) begin
      defer_fired <= 1'b1; // one event per deferral episode
    end else if (!defer_fired) begin
      defer_cnt <= defer_cnt + 19'h00001;
    end
  end

  // transmit events
  // underrun is reported in every cycle the fifo stays empty mid-frame
  assign ev_starve = tx_busy_i && tx_fifo_empty_i; // [R15]
  assign ev_excess = col_pulse && tx_busy_i && (coll_cnt == MAX_COLLISIONS - 5'h01); // [R18]
  assign ev_late = col_pulse && tx_busy_i && (byte_cnt == SLOT_BYTES); // [R19]
  assign ev_nocarr = tx_frame_done_i && !carrier_seen && !crs_sync; // [R17]
  assign ev_parity = tx_fifo_parity_i; // [R20]

  // interrupt only for events whose enable is set
  assign any_irq_event = (ev_starve && tx_ctrl[TC_IRQ_FIFO_STARVE])
    || (defer_hit && tx_ctrl[TC_IRQ_LONG_DEFERRAL]) // [R16]
    || (ev_nocarr && tx_ctrl[TC_IRQ_CARRIER_MISSING])
    || (ev_excess && tx_ctrl[TC_IRQ_TOO_MANY_COLLISIONS])
    || (ev_late && tx_ctrl[TC_IRQ_COLLISION_LATE])
    || (ev_parity && tx_ctrl[TC_IRQ_FIFO_PARITY])
    || (tx_frame_done_i && tx_ctrl[TC_IRQ_FRAME_DONE]); // [R21] [R24]

  // sticky status: hardware set wins over a write-one clear
  // bits 3:0 are read-only; software clears only the event flags above them
  always_comb begin
    set_mask = '0;
    set_mask[TS_TOO_MANY_COLLISIONS] = ev_excess;
    set_mask[TS_FRAME_IRQ] = any_irq_event;
    set_mask[TS_FIFO_STARVE] = ev_starve;
    set_mask[TS_LONG_DEFERRAL] = defer_hit;
    set_mask[TS_CARRIER_MISSING] = ev_nocarr;
    set_mask[TS_COLLISION_LATE] = ev_late;
    set_mask[TS_FIFO_PARITY] = ev_parity; // [R25]
    set_mask[TS_FRAME_DONE] = tx_frame_done_i;
    set_mask[TS_SEND_HALTED] = tx_busy_i && !tx_ctrl[TC_SEND_ALLOW];
    clr_mask = wr_tx_status ? reg_wdata_i[TS_WIDTH-1:0] : '0;
    clr_mask[TS_TOO_MANY_COLLISIONS-1:TS_COLL_COUNT_LSB] = 4'h0;
    next_tx_status = (tx_status & ~clr_mask) | set_mask; // [R24]
    // count field: collisions of the finished frame, zero when excessive
    if (tx_frame_done_i) begin
      next_tx_status[TS_TOO_MANY_COLLISIONS-1:TS_COLL_COUNT_LSB] =
        (coll_cnt == MAX_COLLISIONS) ? 4'h0 : coll_cnt[3:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tx_status <= TX_STATUS_RST;
    end else begin
      tx_status <= next_tx_status;
    end
  end

  // interrupt line: any flagged event whose enable is on
  // enable bit 11 guards the excess flag, which sits at status bit 4
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tx_irq_o <= 1'b0;
    end else begin
      tx_irq_o <= |(next_tx_status[TS_WIDTH-2:TS_FIFO_STARVE]
        & tx_ctrl[TC_WIDTH-1:TC_IRQ_FIFO_STARVE]
        & {1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1})
        | (next_tx_status[TS_TOO_MANY_COLLISIONS] && tx_ctrl[TC_IRQ_TOO_MANY_COLLISIONS]); // [R24]
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  // returning zero between reads keeps stale data off the port
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_FILTER_CTRL: reg_rdata_o <= {{(32-FC_WIDTH){1'b0}}, filter_ctrl}; // [R27]
        ADDR_TX_CTRL: reg_rdata_o <= {{(32-TC_WIDTH){1'b0}}, tx_ctrl}; // [R27]
        ADDR_TX_STATUS: reg_rdata_o <= {{(32-TS_WIDTH){1'b0}}, tx_status};
        default: reg_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

endmodule : matc_ctrl

// [matc_pkg.sv]
package matc_pkg;
  // register byte addresses on the plain register port
  localparam logic [15:0] ADDR_FILTER_CTRL = 16'ha004;
  localparam logic [15:0] ADDR_TX_CTRL = 16'ha008;
  localparam logic [15:0] ADDR_TX_STATUS = 16'ha00c;

  // reset values
  localparam logic [4:0] FILTER_CTRL_RST = 5'h00;
  localparam logic [14:0] TX_CTRL_RST = 15'h0000;
  localparam logic [15:0] TX_STATUS_RST = 16'h0000;

  // address_filter_control fields
  localparam int FC_UNICAST_ACCEPT = 0;
  localparam int FC_MULTICAST_ACCEPT = 1;
  localparam int FC_ALL_ONES_ACCEPT = 2;
  localparam int FC_FILTER_INVERT = 3;
  localparam int FC_LOOKUP_COMPARE_ON = 4;
  localparam int FC_WIDTH = 5;

  // transmit_control fields
  localparam int TC_SEND_ALLOW = 0;
  localparam int TC_SEND_STOP_AFTER_FRAME = 1;
  localparam int TC_PAD_SUPPRESS = 2;
  localparam int TC_FCS_SUPPRESS = 3;
  localparam int TC_QUICK_BACKOFF = 4;
  localparam int TC_DEFERRAL_COUNTER_OFF = 5;
  localparam int TC_CONTROL_FRAME_SEND = 6;
  localparam int TC_HEARTBEAT_TEST_MODE = 7;
  localparam int TC_IRQ_FIFO_STARVE = 8;
  localparam int TC_IRQ_LONG_DEFERRAL = 9;
  localparam int TC_IRQ_CARRIER_MISSING = 10;
  localparam int TC_IRQ_TOO_MANY_COLLISIONS = 11;
  localparam int TC_IRQ_COLLISION_LATE = 12;
  localparam int TC_IRQ_FIFO_PARITY = 13;
  localparam int TC_IRQ_FRAME_DONE = 14;
  localparam int TC_WIDTH = 15;

  // transmit_status fields
  localparam int TS_COLL_COUNT_LSB = 0;
  localparam int TS_TOO_MANY_COLLISIONS = 4;
  localparam int TS_FRAME_IRQ = 7;
  localparam int TS_FIFO_STARVE = 8;
  localparam int TS_LONG_DEFERRAL = 9;
  localparam int TS_CARRIER_MISSING = 10;
  localparam int TS_COLLISION_LATE = 12;
  localparam int TS_FIFO_PARITY = 13;
  localparam int TS_FRAME_DONE = 14;
  localparam int TS_SEND_HALTED = 15;
  localparam int TS_WIDTH = 16;

  // timing: clock period and line limits
  localparam real CLK_PERIOD_NS = 10.0;
  localparam real MAX_DEFER_100M_MS = 0.32768;
  localparam real MAX_DEFER_10M_MS = 3.2768;
  localparam int MAX_DEFER_100M_CYC = int'($floor(MAX_DEFER_100M_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int MAX_DEFER_10M_CYC = int'($floor(MAX_DEFER_10M_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam logic [4:0] MAX_COLLISIONS = 5'd16;
  localparam logic [6:0] SLOT_BYTES = 7'd64;
endpackage : matc_pkg

// [matc_ctrl_asserts.sv]
`timescale 1ns/1ps
module matc_ctrl_chk import matc_pkg::*; #(
  parameter int DEFER_100M_CYCLES = 20,
  parameter int DEFER_10M_CYCLES = 40
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [15:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // address filter
  input wire logic rx_dest_valid_i,
  input wire logic [47:0] rx_dest_addr_i,
  input wire logic cam_hit_i,
  input wire logic rx_decision_valid_o,
  input wire logic rx_accept_o,
  input wire logic cam_compare_o,
  // transmit side
  input wire logic tx_busy_i,
  input wire logic tx_frame_done_i,
  input wire logic tx_abort_o,
  input wire logic pad_suppress_o,
  input wire logic tx_irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [4:0] fc_m;
  logic done_en_m;
  logic exp_acc;
  logic wr_fc;
  logic wr_tc;
  assign wr_fc = reg_wr_i && reg_addr_i == ADDR_FILTER_CTRL;
  assign wr_tc = reg_wr_i && reg_addr_i == ADDR_TX_CTRL;
  // shadows of software-only fields; hardware never changes these bits
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      fc_m <= FILTER_CTRL_RST;
      done_en_m <= 1'b0;
    end else begin
      if (wr_fc) fc_m <= reg_wdata_i[4:0];
      if (wr_tc) done_en_m <= reg_wdata_i[14];
    end
  end
  // decision from current settings, one cycle behind as the design gives it
  always_ff @(posedge core_clk_i) begin
    exp_acc <= ((fc_m[4] & cam_hit_i) ^ fc_m[3]) | (fc_m[0] & ~rx_dest_addr_i[40])
      | (fc_m[1] & rx_dest_addr_i[40] & ~&rx_dest_addr_i) | (fc_m[2] & &rx_dest_addr_i);
  end
  a_decision_pulse: assert property (rx_dest_valid_i |=> rx_decision_valid_o)
    else $error("filter decision pulse missing");
  a_accept_value: assert property (rx_decision_valid_o |-> rx_accept_o == exp_acc)
    else $error("filter accept value wrong");
  a_compare_follow: assert property (wr_fc |=> ##1
    cam_compare_o == $past(reg_wdata_i[4], 2))
    else $error("compare enable not mirrored");
  a_pad_follow: assert property (wr_tc |=> ##1 pad_suppress_o == $past(reg_wdata_i[2], 2))
    else $error("pad suppress not mirrored");
  a_abort_now: assert property (wr_tc && !reg_wdata_i[0] ##1 tx_busy_i [*2] |-> tx_abort_o)
    else $error("send disable did not abort");
  a_filter_reserved: assert property (reg_rd_i && reg_addr_i == ADDR_FILTER_CTRL |=>
    reg_rdata_o[31:5] == '0)
    else $error("filter reserved bits not zero");
  a_txctl_reserved: assert property (reg_rd_i && reg_addr_i == ADDR_TX_CTRL |=>
    reg_rdata_o[31:15] == '0)
    else $error("transmit control reserved bits not zero");
  a_done_irq: assert property (tx_frame_done_i && done_en_m |=> tx_irq_o)
    else $error("frame done interrupt missing");
  c_accepted: cover property (rx_decision_valid_o && rx_accept_o);
  c_aborted: cover property (tx_abort_o);
  c_irq: cover property (tx_irq_o);
endmodule : matc_ctrl_chk

bind matc_ctrl matc_ctrl_chk #(.DEFER_100M_CYCLES(DEFER_100M_CYCLES),
  .DEFER_10M_CYCLES(DEFER_10M_CYCLES)) u_chk (.*);

// [matc_phy_model.sv]
`timescale 1ns/1ps
module matc_phy_model (
  // transmit activity seen on the line
  input wire logic tx_busy_i,
  // line pins toward the controller
  output logic carrier_present_o,
  output logic collision_o
);
  logic echo = 1'b1;
  logic line_busy = 1'b0;
  // carrier echoes our own frame unless the bench cuts it, or another station holds the line
  assign carrier_present_o = (tx_busy_i & echo) | line_busy;
  initial collision_o = 1'b0;
  // jams wide enough that the two-flop sync never drops one
  task automatic collide(input int n);
    // start half a period late so no pin change meets a clock edge
    #5;
    repeat (n) begin
      #30 collision_o = 1'b1;
      #30 collision_o = 1'b0;
    end
  endtask : collide
endmodule : matc_phy_model

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import matc_pkg::*;
  // design inputs, idle at time zero
  logic core_clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [15:0] reg_addr_i = '0;
  logic [31:0] reg_wdata_i = '0, reg_rdata_o, d;
  logic rx_dest_valid_i = 1'b0, cam_hit_i = 1'b0, tx_pending_i = 1'b0, tx_busy_i = 1'b0;
  logic tx_byte_i = 1'b0, tx_fifo_empty_i = 1'b0, tx_fifo_parity_i = 1'b0;
  logic tx_frame_done_i = 1'b0, tx_ctl_frame_done_i = 1'b0, speed_10m_i = 1'b0;
  logic [47:0] rx_dest_addr_i = '0;
  // design outputs and line pins
  logic carrier_present_i, collision_i, rx_decision_valid_o, rx_accept_o, cam_compare_o;
  logic tx_start_ok_o, tx_abort_o, pad_suppress_o, fcs_suppress_o, quick_backoff_o;
  logic heartbeat_test_mode_o, control_frame_req_o, excess_abort_o, tx_irq_o;
  int errors = 0, checks_done = 0;
  int aborts = 0;
  // station, group and all-ones destinations; event enable and status bit pairs
  logic [47:0] adr [3] = '{48'h0200_0000_0001, 48'h0100_5e00_0001, 48'hffff_ffff_ffff};
  int enb [7] = '{8, 13, 14, 10, 11, 12, 9};
  int stb [7] = '{8, 13, 14, 10, 4, 12, 9};
  always #5 core_clk_i = ~core_clk_i;
  // excess_abort_o is a one-cycle pulse, so count it where it stands
  always @(posedge core_clk_i) begin
    if (excess_abort_o) aborts++;
  end
  // short deferral limits keep the run brief
  matc_ctrl #(.DEFER_100M_CYCLES(20), .DEFER_10M_CYCLES(40)) DUT (.*);
  matc_phy_model phy (.tx_busy_i(tx_busy_i), .carrier_present_o(carrier_present_i),
    .collision_o(collision_i));
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : cyc
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    cyc(1);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    cyc(1);
    reg_wr_i <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a);
    cyc(1);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    cyc(1);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rd
  function automatic logic acc(input logic [4:0] f, input int t, input logic h);
    return ((f[4] & h) ^ f[3]) | (f[0] & t == 0) | (f[1] & t == 1) | (f[2] & t == 2);
  endfunction : acc
  // one transmit event: 0 starve, 1 parity, 2 done, 3 no carrier, 4 excess, 5 late, 6 defer
  task automatic fire(input int i);
    phy.echo = (i != 3);
    cyc(1);
    tx_busy_i <= (i != 6);
    tx_pending_i <= (i == 6);
    phy.line_busy = (i == 6);
    tx_fifo_empty_i <= (i == 0);
    tx_fifo_parity_i <= (i == 1);
    tx_byte_i <= (i == 5);
    cyc(1);
    tx_fifo_empty_i <= 1'b0;
    tx_fifo_parity_i <= 1'b0;
    cyc(i == 5 ? 70 : i == 6 ? 50 : 3);
    tx_byte_i <= 1'b0;
    if (i == 4) phy.collide(16);
    if (i == 5) phy.collide(1);
    cyc(4);
    tx_frame_done_i <= (i inside {2, 3, 4});
    cyc(1);
    tx_frame_done_i <= 1'b0;
    tx_busy_i <= 1'b0;
    tx_pending_i <= 1'b0;
    phy.line_busy = 1'b0;
  endtask : fire
  task automatic summarize;
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  // hang guard, far beyond the roughly 1250 cycles the sequence needs
  initial begin
    #300000;
    errors++;
    summarize();
  end
  initial begin
    cyc(16);
    sys_rst_i <= 1'b0;
    rd(ADDR_TX_CTRL);
    chk(d, 32'(TX_CTRL_RST));
    rd(ADDR_FILTER_CTRL);
    chk(d, 32'(FILTER_CTRL_RST));
    // every filter setting against each address class, with and without a lookup hit
    for (int f = 0; f < 32; f++) begin
      wr(ADDR_FILTER_CTRL, 32'(f));
      for (int k = 0; k < 6; k++) begin
        cyc(1);
        rx_dest_valid_i <= 1'b1;
        rx_dest_addr_i <= adr[k / 2];
        cam_hit_i <= k[0];
        cyc(1);
        rx_dest_valid_i <= 1'b0;
        #1 chk(32'({rx_decision_valid_o, rx_accept_o}),
          32'({1'b1, acc(f[4:0], k / 2, k[0])}));
        chk(32'(cam_compare_o), 32'(f[4]));
      end
    end
    wr(ADDR_FILTER_CTRL, '1);
    rd(ADDR_FILTER_CTRL);
    chk(d, 32'h1f);
    wr(ADDR_TX_CTRL, '1);
    rd(ADDR_TX_CTRL);
    chk(d, 32'h7fff);
    chk(32'({pad_suppress_o, fcs_suppress_o, quick_backoff_o, heartbeat_test_mode_o,
      control_frame_req_o, tx_start_ok_o}), 32'h3e);
    wr(ADDR_TX_CTRL, 32'h0);
    rd(ADDR_TX_CTRL);
    chk(d, 32'h40);
    chk(32'({pad_suppress_o, control_frame_req_o}), 32'h1);
    wr(ADDR_TX_CTRL, 32'h1);
    cyc(1);
    tx_ctl_frame_done_i <= 1'b1;
    cyc(1);
    tx_ctl_frame_done_i <= 1'b0;
    rd(ADDR_TX_CTRL);
    chk(d, 32'h1);
    chk(32'(tx_start_ok_o), 32'h1);
    wr(16'ha010, '1);
    rd(16'ha010);
    chk(d, 32'h0);
    // clearing send permission mid-frame must abort at once
    cyc(1);
    tx_busy_i <= 1'b1;
    wr(ADDR_TX_CTRL, 32'h0);
    cyc(1);
    #1 chk(32'(tx_abort_o), 32'h1);
    cyc(1);
    tx_busy_i <= 1'b0;
    wr(ADDR_TX_STATUS, 32'hfff0);
    wr(ADDR_TX_CTRL, 32'h0220);
    fire(6);
    #1 chk(32'(tx_irq_o), 32'h0);
    // each event with its enable off, then on; status always, interrupt only when enabled
    for (int i = 0; i < 14; i++) begin
      wr(ADDR_TX_STATUS, 32'hfff0);
      wr(ADDR_TX_CTRL, 32'(i[0]) << enb[i / 2] | 32'h1);
      speed_10m_i <= i[0];
      fire(i / 2);
      rd(ADDR_TX_STATUS);
      chk(32'(d[stb[i / 2]]), 32'h1);
      chk(32'(tx_irq_o), 32'(i[0]));
      rd(ADDR_TX_CTRL);
      if (i inside {2, 3}) chk(32'(d[0]), 32'(i == 2));
    end
    chk(32'(aborts), 32'h2);
    summarize();
  end
endmodule : tb_top
